// *** hw/core_regs_pkg.sv ***
package core_regs_pkg;
  localparam int unsigned CLK_HZ       = 25_000_000;
  localparam int unsigned MOD_FREQ_HZ  = 38_000;
  localparam int unsigned MOD_HALF_CYC = CLK_HZ / (2 * MOD_FREQ_HZ);
  localparam logic [8:0]  MOD_HALF_CNT = 9'(MOD_HALF_CYC - 1);

  localparam logic [7:0]  SFR_SP       = 8'h81;
  localparam logic [7:0]  SFR_PTR_LO   = 8'h82;
  localparam logic [7:0]  SFR_PTR_HI   = 8'h83;
  localparam logic [7:0]  SFR_CFG      = 8'haf;
  localparam logic [7:0]  SFR_PSW      = 8'hd0;
  localparam logic [7:0]  SFR_ACC      = 8'he0;
  localparam logic [7:0]  SFR_B        = 8'hf0;
  localparam logic [7:0]  BIT_BYTE_MSK = 8'hf8;

  localparam logic [7:0]  SP_RST       = 8'h07;
  localparam logic [15:0] PC_RST       = 16'h0000;
  localparam logic [7:0]  CFG_RST      = 8'h80;
  localparam logic [7:0]  CFG_WR_MSK   = 8'hf3;
  localparam logic [7:0]  BYTE_RST     = 8'h00;
  localparam logic [15:0] PTR_RST      = 16'h0000;

  localparam int unsigned EXT_INTERNAL_RAM_AW      = 8;
  localparam int unsigned EXT_INTERNAL_RAM_BYTES   = 256;
  localparam int unsigned BANK_AW      = 5;
  localparam int unsigned BANK_BYTES   = 32;

  typedef struct packed {
    logic       cy;
    logic       ac;
    logic       f0;
    logic [1:0] bank;
    logic       ov;
    logic       f1;
    logic       p;
  } psw_s;

  typedef struct packed {
    logic       keep_set;
    logic       uart_enhance_sel;
    logic       sync_port_sel;
    logic       ir_mod_enable;
    logic [1:0] rsv;
    logic [1:0] ext_internal_ram_en_bits;
  } cfg_s;

  typedef enum logic [1:0] {ST_IDLE, ST_CALL_HI, ST_RET_LO, ST_RET_LOAD} stk_state_e;

  // modulo-256 step keeps every stack access inside extended RAM
  function automatic logic [7:0] sp_step(input logic [7:0] sp, input logic up);
    sp_step = up ? 8'(sp + 8'h01) : 8'(sp - 8'h01);
  endfunction
endpackage

// *** hw/ext_internal_ram_store.sv ***
`timescale 1ns/100ps
module ext_internal_ram_store
  import core_regs_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic               nrst,
  input  wire logic               en,
  input  wire logic               we,
  input  wire logic [EXT_INTERNAL_RAM_AW-1:0] addr,
  input  wire logic [7:0]         wdata,
  output logic [7:0]              rdata
);
  logic [7:0] mem [0:EXT_INTERNAL_RAM_BYTES-1];
  logic [7:0] rdata_r;

  always_ff @(posedge ref_clk) begin
    if (en && we) begin
      mem[addr] <= wdata;
    end
  end

  // read-before-write: a same-cycle write returns the old byte
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rdata_r <= BYTE_RST;
    end else if (en) begin
      rdata_r <= mem[addr];
    end
  end

  assign rdata = rdata_r;
endmodule

// *** hw/bank_store.sv ***
`timescale 1ns/100ps
module bank_store
  import core_regs_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic               nrst,
  input  wire logic [BANK_AW-1:0] a_addr,
  input  wire logic               a_we,
  input  wire logic [7:0]         a_wdata,
  output logic [7:0]              a_rdata,
  input  wire logic [BANK_AW-1:0] b_addr,
  input  wire logic               b_we,
  input  wire logic [7:0]         b_wdata,
  output logic [7:0]              b_rdata
);
  logic [7:0] mem [0:BANK_BYTES-1];
  logic [7:0] a_rdata_r;
  logic [7:0] b_rdata_r;

  // register port wins when both ports write one byte
  always_ff @(posedge ref_clk) begin
    if (b_we && !(a_we && a_addr == b_addr)) begin
      mem[b_addr] <= b_wdata;
    end
    if (a_we) begin
      mem[a_addr] <= a_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      a_rdata_r <= BYTE_RST;
      b_rdata_r <= BYTE_RST;
    end else begin
      a_rdata_r <= mem[a_addr];
      b_rdata_r <= mem[b_addr];
    end
  end

  assign a_rdata = a_rdata_r;
  assign b_rdata = b_rdata_r;
endmodule

// *** hw/core_regs.sv ***
`timescale 1ns/100ps
module core_regs
  import core_regs_pkg::*;
(
  input  wire logic         ref_clk,
  input  wire logic         nrst,
  input  wire logic [7:0]   sfr_addr,
  input  wire logic         sfr_wr,
  input  wire logic         sfr_rd,
  input  wire logic [7:0]   sfr_wdata,
  output logic [7:0]        sfr_rdata,
  output logic              sfr_rvalid,
  input  wire logic [7:0]   bit_addr,
  input  wire logic         bit_set,
  input  wire logic         bit_clr,
  input  wire logic         bit_test,
  output logic              bit_val,
  input  wire logic [2:0]   reg_idx,
  input  wire logic         reg_wr,
  input  wire logic [7:0]   reg_wdata,
  output logic [7:0]        reg_rdata,
  input  wire logic [4:0]   dram_addr,
  input  wire logic         dram_wr,
  input  wire logic [7:0]   dram_wdata,
  output logic [7:0]        dram_rdata,
  input  wire logic         acc_we,
  input  wire logic [7:0]   acc_wdata,
  input  wire logic         flag_we,
  input  wire logic         flag_cy,
  input  wire logic         flag_ac,
  input  wire logic         flag_ov,
  input  wire logic         b_we,
  input  wire logic [7:0]   b_wdata,
  input  wire logic         ptr_we,
  input  wire logic [15:0]  ptr_wdata,
  input  wire logic         ptr_sel,
  input  wire logic         instr_done,
  input  wire logic [1:0]   instr_len,
  input  wire logic         jump_load,
  input  wire logic [15:0]  jump_target,
  input  wire logic         op_load,
  input  wire logic [7:0]   op_code,
  input  wire logic         push_req,
  input  wire logic [7:0]   push_data,
  input  wire logic         pop_req,
  input  wire logic         call_req,
  input  wire logic [15:0]  call_target,
  input  wire logic         ret_req,
  input  wire logic         xmov_rd,
  input  wire logic         xmov_wr,
  input  wire logic [7:0]   xmov_addr,
  input  wire logic [7:0]   xmov_wdata,
  input  wire logic [7:0]   mod_pin_select,
  output logic [7:0]        stk_rdata,
  output logic              pop_valid,
  output logic              xmov_valid,
  output logic              busy,
  output logic [15:0]       pc_q,
  output logic [7:0]        opcode_q,
  output logic [7:0]        acc_q,
  output logic [7:0]        b_q,
  output psw_s              psw_q,
  output logic [15:0]       ptr_q,
  output logic              uart_enhance_sel,
  output logic              sync_port_sel,
  output logic              ext_internal_ram_enable,
  output logic [7:0]        mod_out
);
  // core register group
  logic [7:0]  acc_r, acc_nxt;
  logic [7:0]  b_r, b_nxt;
  psw_s        psw_r, psw_nxt;
  logic [15:0] ptr0_r, ptr0_nxt;
  logic [15:0] ptr1_r, ptr1_nxt;
  logic [15:0] ptr_act_r, ptr_act_nxt;
  cfg_s        cfg_r, cfg_nxt;
  logic        ext_internal_ram_en_r, ext_internal_ram_en_nxt;
  logic [7:0]  sfr_rdata_r, sfr_rdata_nxt;
  logic        sfr_rvalid_r;
  logic        bit_val_r, bit_val_nxt;
  logic [7:0]  opcode_r, opcode_nxt;

  // shared decode
  logic        bit_op, wr_en;
  logic [7:0]  acc_addr, rd_byte, wr_byte;
  logic [15:0] ptr_cur, ptr_upd;

  // stack group
  stk_state_e  st_r, st_nxt;
  logic [7:0]  sp_r, sp_nxt;
  logic [15:0] pc_r, pc_nxt;
  logic [15:0] tgt_r, tgt_nxt;
  logic [7:0]  ret_hi_r, ret_hi_nxt;
  logic        pop_valid_r, pop_valid_nxt;
  logic        xmov_valid_r, xmov_valid_nxt;
  logic        busy_r, busy_nxt;
  logic        x_en, x_we, xmov_ok;
  logic [7:0]  x_addr, x_wdata, x_rdata;

  // modulation group
  logic [8:0]  div_r, div_nxt;
  logic        carrier_r, carrier_nxt;
  logic        half_tick;
  logic [7:0]  mod_out_r, mod_out_nxt;

  // one address path serves byte access and bit access
  always_comb begin
    bit_op   = bit_set | bit_clr | bit_test;
    acc_addr = bit_op ? (bit_addr & BIT_BYTE_MSK) : sfr_addr;
    ptr_cur  = ptr_sel ? ptr1_r : ptr0_r;
    unique case (acc_addr)
      SFR_ACC: rd_byte = acc_r;
      SFR_B:   rd_byte = b_r;
      SFR_PSW: rd_byte = psw_r;
      SFR_PTR_LO: rd_byte = ptr_cur[7:0];
      SFR_PTR_HI: rd_byte = ptr_cur[15:8];
      SFR_SP:  rd_byte = sp_r;
      SFR_CFG: rd_byte = cfg_r;
      // pc and opcode have no address at all
      default: rd_byte = 8'h00;
    endcase
    wr_en   = sfr_wr | bit_set | bit_clr;
    wr_byte = sfr_wdata;
    if (bit_set || bit_clr) begin
      wr_byte              = rd_byte;
      wr_byte[bit_addr[2:0]] = bit_set;
    end
  end

  always_comb begin
    acc_nxt = acc_r;
    if (acc_we) acc_nxt = acc_wdata;
    if (wr_en && acc_addr == SFR_ACC) acc_nxt = wr_byte;

    b_nxt = b_r;
    if (b_we) b_nxt = b_wdata;
    if (wr_en && acc_addr == SFR_B) b_nxt = wr_byte;

    psw_nxt = psw_r;
    if (flag_we) begin
      psw_nxt.cy = flag_cy;
      psw_nxt.ac = flag_ac;
      psw_nxt.ov = flag_ov;
    end
    if (wr_en && acc_addr == SFR_PSW) psw_nxt = wr_byte;
    // parity follows the accumulator every cycle, writes to it are lost
    psw_nxt.p = ^acc_nxt;

    ptr_upd = ptr_cur;
    if (ptr_we) ptr_upd = ptr_wdata;
    if (wr_en && acc_addr == SFR_PTR_LO) ptr_upd[7:0] = wr_byte;
    if (wr_en && acc_addr == SFR_PTR_HI) ptr_upd[15:8] = wr_byte;
    ptr0_nxt    = ptr_sel ? ptr0_r : ptr_upd;
    ptr1_nxt    = ptr_sel ? ptr_upd : ptr1_r;
    ptr_act_nxt = ptr_upd;

    cfg_nxt = cfg_r;
    if (wr_en && acc_addr == SFR_CFG) begin
      // bit 7 stays writable; clearing it is the user's fault
      cfg_nxt = wr_byte & CFG_WR_MSK;
    end
    ext_internal_ram_en_nxt = |cfg_nxt.ext_internal_ram_en_bits;

    sfr_rdata_nxt = sfr_rd ? rd_byte : sfr_rdata_r;
    bit_val_nxt   = bit_test ? rd_byte[bit_addr[2:0]] : bit_val_r;
    opcode_nxt    = op_load ? op_code : opcode_r;
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      acc_r        <= BYTE_RST;
      b_r          <= BYTE_RST;
      psw_r        <= BYTE_RST;
      ptr0_r       <= PTR_RST;
      ptr1_r       <= PTR_RST;
      ptr_act_r    <= PTR_RST;
      cfg_r        <= CFG_RST;
      ext_internal_ram_en_r    <= |CFG_RST[1:0];
      sfr_rdata_r  <= BYTE_RST;
      sfr_rvalid_r <= 1'b0;
      bit_val_r    <= 1'b0;
      opcode_r     <= BYTE_RST;
    end else begin
      acc_r        <= acc_nxt;
      b_r          <= b_nxt;
      psw_r        <= psw_nxt;
      ptr0_r       <= ptr0_nxt;
      ptr1_r       <= ptr1_nxt;
      ptr_act_r    <= ptr_act_nxt;
      cfg_r        <= cfg_nxt;
      ext_internal_ram_en_r    <= ext_internal_ram_en_nxt;
      sfr_rdata_r  <= sfr_rdata_nxt;
      sfr_rvalid_r <= sfr_rd;
      bit_val_r    <= bit_val_nxt;
      opcode_r     <= opcode_nxt;
    end
  end

  // stack and extended moves share one single-port store
  always_comb begin
    st_nxt         = st_r;
    sp_nxt         = sp_r;
    pc_nxt         = pc_r;
    tgt_nxt        = tgt_r;
    ret_hi_nxt     = ret_hi_r;
    pop_valid_nxt  = 1'b0;
    xmov_valid_nxt = 1'b0;
    x_en           = 1'b0;
    x_we           = 1'b0;
    x_addr         = sp_r;
    x_wdata        = push_data;
    xmov_ok        = (xmov_rd | xmov_wr) & ext_internal_ram_en_r;
    if (wr_en && acc_addr == SFR_SP) begin
      sp_nxt = wr_byte;
    end
    if (instr_done) begin
      pc_nxt = pc_r + {14'h0000, instr_len};
    end
    if (jump_load) begin
      pc_nxt = jump_target;
    end
    unique case (st_r)
      ST_IDLE: begin
        if (call_req) begin
          x_en       = 1'b1;
          x_we       = 1'b1;
          x_addr     = sp_step(sp_r, 1'b1);
          x_wdata    = pc_r[7:0];
          sp_nxt     = x_addr;
          tgt_nxt    = call_target;
          ret_hi_nxt = pc_r[15:8];
          st_nxt     = ST_CALL_HI;
        end else if (ret_req) begin
          x_en   = 1'b1;
          sp_nxt = sp_step(sp_r, 1'b0);
          st_nxt = ST_RET_LO;
        end else if (push_req) begin
          x_en    = 1'b1;
          x_we    = 1'b1;
          x_addr  = sp_step(sp_r, 1'b1);
          x_wdata = push_data;
          sp_nxt  = x_addr;
        end else if (pop_req) begin
          x_en          = 1'b1;
          sp_nxt        = sp_step(sp_r, 1'b0);
          pop_valid_nxt = 1'b1;
        end else if (xmov_ok) begin
          x_en           = 1'b1;
          x_we           = xmov_wr;
          x_addr         = xmov_addr;
          x_wdata        = xmov_wdata;
          xmov_valid_nxt = xmov_rd;
        end
      end
      ST_CALL_HI: begin
        x_en    = 1'b1;
        x_we    = 1'b1;
        x_addr  = sp_step(sp_r, 1'b1);
        x_wdata = ret_hi_r;
        sp_nxt  = x_addr;
        pc_nxt  = tgt_r;
        st_nxt  = ST_IDLE;
      end
      ST_RET_LO: begin
        x_en       = 1'b1;
        sp_nxt     = sp_step(sp_r, 1'b0);
        ret_hi_nxt = x_rdata;
        st_nxt     = ST_RET_LOAD;
      end
      ST_RET_LOAD: begin
        pc_nxt = {ret_hi_r, x_rdata};
        st_nxt = ST_IDLE;
      end
    endcase
    busy_nxt = (st_nxt != ST_IDLE);
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st_r         <= ST_IDLE;
      sp_r         <= SP_RST;
      pc_r         <= PC_RST;
      tgt_r        <= PC_RST;
      ret_hi_r     <= BYTE_RST;
      pop_valid_r  <= 1'b0;
      xmov_valid_r <= 1'b0;
      busy_r       <= 1'b0;
    end else begin
      st_r         <= st_nxt;
      sp_r         <= sp_nxt;
      pc_r         <= pc_nxt;
      tgt_r        <= tgt_nxt;
      ret_hi_r     <= ret_hi_nxt;
      pop_valid_r  <= pop_valid_nxt;
      xmov_valid_r <= xmov_valid_nxt;
      busy_r       <= busy_nxt;
    end
  end

  ext_internal_ram_store u_ext_internal_ram (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .en      (x_en),
    .we      (x_we),
    .addr    (x_addr),
    .wdata   (x_wdata),
    .rdata   (x_rdata)
  );

  // working registers sit at {bank, index} in the low data RAM
  bank_store u_bank (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .a_addr  ({psw_r.bank, reg_idx}),
    .a_we    (reg_wr),
    .a_wdata (reg_wdata),
    .a_rdata (reg_rdata),
    .b_addr  (dram_addr),
    .b_we    (dram_wr),
    .b_wdata (dram_wdata),
    .b_rdata (dram_rdata)
  );

  // carrier divider stops while disabled so each burst starts low
  always_comb begin
    half_tick   = (div_r == MOD_HALF_CNT);
    div_nxt     = half_tick ? 9'h000 : 9'(div_r + 9'h001);
    carrier_nxt = half_tick ? ~carrier_r : carrier_r;
    if (!cfg_r.ir_mod_enable) begin
      div_nxt     = 9'h000;
      carrier_nxt = 1'b0;
    end
    mod_out_nxt = cfg_r.ir_mod_enable ? ({8{carrier_r}} & mod_pin_select) : 8'h00;
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      div_r     <= 9'h000;
      carrier_r <= 1'b0;
      mod_out_r <= 8'h00;
    end else begin
      div_r     <= div_nxt;
      carrier_r <= carrier_nxt;
      mod_out_r <= mod_out_nxt;
    end
  end

  assign sfr_rdata        = sfr_rdata_r;
  assign sfr_rvalid       = sfr_rvalid_r;
  assign bit_val          = bit_val_r;
  assign stk_rdata        = x_rdata;
  assign pop_valid        = pop_valid_r;
  assign xmov_valid       = xmov_valid_r;
  assign busy             = busy_r;
  assign pc_q             = pc_r;
  assign opcode_q         = opcode_r;
  assign acc_q            = acc_r;
  assign b_q              = b_r;
  assign psw_q            = psw_r;
  assign ptr_q            = ptr_act_r;
  assign uart_enhance_sel = cfg_r.uart_enhance_sel;
  assign sync_port_sel    = cfg_r.sync_port_sel;
  assign ext_internal_ram_enable      = ext_internal_ram_en_r;
  assign mod_out          = mod_out_r;
endmodule

// *** testbench/core_regs_sva.sv ***
`timescale 1ns/100ps
module core_regs_sva
  import core_regs_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic [7:0]  sfr_addr,
  input wire logic        sfr_wr,
  input wire logic [7:0]  sfr_wdata,
  input wire logic        bit_set,
  input wire logic        bit_clr,
  input wire logic        bit_test,
  input wire logic        instr_done,
  input wire logic [1:0]  instr_len,
  input wire logic        jump_load,
  input wire logic [15:0] jump_target,
  input wire logic        op_load,
  input wire logic [7:0]  op_code,
  input wire logic        push_req,
  input wire logic        pop_req,
  input wire logic        call_req,
  input wire logic [15:0] call_target,
  input wire logic        ret_req,
  input wire logic        xmov_rd,
  input wire logic        pop_valid,
  input wire logic        xmov_valid,
  input wire logic        busy,
  input wire logic [15:0] pc_q,
  input wire logic [7:0]  opcode_q,
  input wire logic [7:0]  acc_q,
  input wire psw_s        psw_q,
  input wire logic        uart_enhance_sel,
  input wire logic        sync_port_sel,
  input wire logic        ext_internal_ram_enable
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // stack sequences override the counter, so only quiet cycles are judged
  logic stk_idle;
  assign stk_idle = !busy && !call_req && !ret_req;
  // a bit op takes over the address path, so the decode check stands aside
  logic bit_op;
  assign bit_op = bit_set || bit_clr || bit_test;

  a_parity_even: assert property (^{acc_q, psw_q.p} == 1'b0)
    else $error("parity flag disagrees with accumulator");
  a_pc_advance: assert property (instr_done && !jump_load && stk_idle
    |=> pc_q == $past(pc_q) + 16'($past(instr_len)))
    else $error("program counter did not advance by length");
  a_jump_load: assert property (jump_load && stk_idle
    |=> pc_q == $past(jump_target))
    else $error("jump target not loaded");
  a_call_seq: assert property (call_req && !busy
    |=> busy ##1 (!busy && pc_q == $past(call_target, 2)))
    else $error("call sequence wrong");
  a_ret_busy: assert property (ret_req && !busy && !call_req |=> busy[*2] ##1 !busy)
    else $error("return sequence length wrong");
  a_pop_valid: assert property (pop_req && stk_idle && !push_req |=> pop_valid)
    else $error("pop gave no valid");
  a_cfg_decode: assert property (sfr_wr && sfr_addr == SFR_CFG && !bit_op
    |=> uart_enhance_sel == $past(sfr_wdata[6]) && sync_port_sel == $past(sfr_wdata[5])
        && ext_internal_ram_enable == (|$past(sfr_wdata[1:0])))
    else $error("configuration outputs wrong");
  a_xmov_gate: assert property (xmov_rd && !ext_internal_ram_enable |=> !xmov_valid)
    else $error("extended move answered while disabled");
  a_opcode_hold: assert property (op_load |=> opcode_q == $past(op_code))
    else $error("opcode not captured");

  c_call: cover property (call_req && !busy);
  c_ret: cover property (ret_req && !busy);
  c_pop: cover property (pop_valid);
  c_xmov_off: cover property (xmov_rd && !ext_internal_ram_enable);
endmodule

bind core_regs core_regs_sva chk_u (.*);

// *** testbench/core_regs_test.sv ***
`timescale 1ns/100ps
module core_regs_test import core_regs_pkg::*;;
  logic        ref_clk = 1'b0, nrst = 1'b0;
  logic        sfr_wr = 1'b0, sfr_rd = 1'b0, bit_set = 1'b0, bit_clr = 1'b0, bit_test = 1'b0;
  logic        reg_wr = 1'b0, dram_wr = 1'b0, acc_we = 1'b0, flag_we = 1'b0, b_we = 1'b0;
  logic        flag_cy = 1'b0, flag_ac = 1'b0, flag_ov = 1'b0, ptr_we = 1'b0, ptr_sel = 1'b0;
  logic        instr_done = 1'b0, jump_load = 1'b0, op_load = 1'b0, push_req = 1'b0;
  logic        pop_req = 1'b0, call_req = 1'b0, ret_req = 1'b0, xmov_rd = 1'b0, xmov_wr = 1'b0;
  logic [1:0]  instr_len = 2'h0;
  logic [2:0]  reg_idx = 3'h0;
  logic [4:0]  dram_addr = 5'h00;
  logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, bit_addr = 8'h00, reg_wdata = 8'h00;
  logic [7:0]  dram_wdata = 8'h00, acc_wdata = 8'h00, b_wdata = 8'h00, op_code = 8'h00;
  logic [7:0]  push_data = 8'h00, xmov_addr = 8'h00, xmov_wdata = 8'h00, mod_pin_select = 8'h00;
  logic [15:0] ptr_wdata = 16'h0000, jump_target = 16'h0000, call_target = 16'h0000;
  logic [7:0]  sfr_rdata, reg_rdata, dram_rdata, stk_rdata, opcode_q, acc_q, b_q, mod_out;
  logic        sfr_rvalid, bit_val, pop_valid, xmov_valid, busy;
  logic        uart_enhance_sel, sync_port_sel, ext_internal_ram_enable;
  logic [15:0] pc_q, ptr_q;
  psw_s        psw_q;
  int          error_cnt = 0, checks = 0, pcx = 0;
  logic [7:0]  m1, v;
  logic [7:0]  cfg_tab [4] = '{8'hc1, 8'ha2, 8'h83, 8'h9c};

  always #20 ref_clk = ~ref_clk;
  core_regs dut_u (.*);

  task automatic nx();
    @(negedge ref_clk);
  endtask
  task automatic conclude();
    if (error_cnt == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // strobe returns low for a whole cycle so back-to-back calls never collide
  task automatic strobe(ref logic s);
    s = 1'b1;
    nx();
    s = 1'b0;
    nx();
  endtask
  task automatic sfr_put(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    strobe(sfr_wr);
  endtask
  task automatic sfr_get(input logic [7:0] a, input logic [7:0] exp);
    sfr_addr = a;
    sfr_rd = 1'b1;
    nx();
    sfr_rd = 1'b0;
    chk("sfr_rvalid", 16'(sfr_rvalid), 16'h0001);
    chk("sfr_rdata", 16'(sfr_rdata), 16'(exp));
    nx();
  endtask
  // valid stands one cycle only, so it is sampled right after the taking edge
  task automatic grab(ref logic s, ref logic vld, input logic [7:0] exp);
    s = 1'b1;
    nx();
    s = 1'b0;
    chk("stack valid", 16'(vld), 16'h0001);
    chk("stk_rdata", 16'(stk_rdata), 16'(exp));
    nx();
  endtask

  initial begin
    repeat (3000) @(posedge ref_clk);
    error_cnt++;
    conclude();
  end

  initial begin
    repeat (3) nx();
    nrst = 1'b1;
    nx();
    chk("pc_q", pc_q, 16'h0000);
    sfr_get(8'h81, 8'h07);
    sfr_get(8'haf, 8'h80);
    sfr_get(8'h90, 8'h00);
    mod_pin_select = 8'h5a;
    foreach (cfg_tab[i]) begin
      v = cfg_tab[i];
      sfr_put(8'haf, v);
      chk("uart_enhance_sel", 16'(uart_enhance_sel), 16'(v[6]));
      chk("sync_port_sel", 16'(sync_port_sel), 16'(v[5]));
      chk("ext_internal_ram_enable", 16'(ext_internal_ram_enable), 16'(|v[1:0]));
      sfr_get(8'haf, v & 8'hf3);
    end
    // both enable bits clear: the move is dropped, no valid, no new byte
    xmov_rd = 1'b1;
    nx();
    xmov_rd = 1'b0;
    chk("xmov_valid", 16'(xmov_valid), 16'h0000);
    chk("stk_rdata", 16'(stk_rdata), 16'h0000);
    nx();
    m1 = mod_out;
    // any run of one half period holds exactly one carrier edge
    repeat (MOD_HALF_CYC) nx();
    chk("mod_out toggle", 16'(m1 ^ mod_out), 16'h005a);
    sfr_put(8'haf, 8'h81);
    nx();
    chk("mod_out", 16'(mod_out), 16'h0000);
    for (int n = 1; n <= 3; n++) begin
      instr_len = 2'(n);
      strobe(instr_done);
      pcx += n;
      chk("pc_q", pc_q, 16'(pcx));
    end
    // step and jump in one cycle: the jump wins
    instr_done = 1'b1;
    jump_target = 16'h1234;
    jump_load = 1'b1;
    nx();
    instr_done = 1'b0;
    jump_load = 1'b0;
    nx();
    chk("pc_q", pc_q, 16'h1234);
    op_code = 8'ha5;
    strobe(op_load);
    chk("opcode_q", 16'(opcode_q), 16'h00a5);
    reg_idx = 3'h5;
    for (int b = 0; b < 4; b++) begin
      sfr_put(8'hd0, 8'(b << 3));
      reg_wdata = 8'(8'h10 + b);
      strobe(reg_wr);
      chk("reg_rdata", 16'(reg_rdata), 16'(8'h10 + b));
    end
    chk("reg_rdata", 16'(reg_rdata), 16'h0013);
    for (int b = 0; b < 4; b++) begin
      dram_addr = 5'(b * 8 + 5);
      repeat (2) nx();
      chk("dram_rdata", 16'(dram_rdata), 16'(8'h10 + b));
    end
    bit_addr = 8'hd3;
    strobe(bit_clr);
    chk("reg_rdata", 16'(reg_rdata), 16'h0012);
    bit_addr = 8'hd4;
    strobe(bit_test);
    chk("bit_val", 16'(bit_val), 16'h0001);
    strobe(bit_clr);
    chk("reg_rdata", 16'(reg_rdata), 16'h0010);
    acc_wdata = 8'h07;
    strobe(acc_we);
    chk("acc_q", 16'(acc_q), 16'h0007);
    chk("parity", 16'(psw_q.p), 16'h0001);
    sfr_get(8'he0, 8'h07);
    sfr_put(8'he0, 8'h03);
    chk("parity", 16'(psw_q.p), 16'h0000);
    {flag_cy, flag_ac, flag_ov} = 3'b101;
    strobe(flag_we);
    sfr_get(8'hd0, 8'h84);
    sfr_put(8'hd0, 8'h01);
    sfr_get(8'hd0, 8'h00);
    b_wdata = 8'h3c;
    strobe(b_we);
    chk("b_q", 16'(b_q), 16'h003c);
    sfr_get(8'hf0, 8'h3c);
    ptr_wdata = 16'hbeef;
    strobe(ptr_we);
    sfr_put(8'h82, 8'h12);
    chk("ptr_q", ptr_q, 16'hbe12);
    ptr_sel = 1'b1;
    ptr_wdata = 16'h5678;
    strobe(ptr_we);
    sfr_get(8'h83, 8'h56);
    ptr_sel = 1'b0;
    sfr_put(8'h83, 8'h77);
    chk("ptr_q", ptr_q, 16'h7712);
    sfr_put(8'h81, 8'hff);
    push_data = 8'h5a;
    strobe(push_req);
    push_data = 8'h6b;
    strobe(push_req);
    sfr_get(8'h81, 8'h01);
    xmov_addr = 8'h00;
    grab(xmov_rd, xmov_valid, 8'h5a);
    grab(pop_req, pop_valid, 8'h6b);
    grab(pop_req, pop_valid, 8'h5a);
    sfr_get(8'h81, 8'hff);
    xmov_addr = 8'h10;
    xmov_wdata = 8'hc3;
    strobe(xmov_wr);
    sfr_put(8'h81, 8'h10);
    grab(pop_req, pop_valid, 8'hc3);
    sfr_put(8'h81, 8'h07);
    call_target = 16'h4000;
    call_req = 1'b1;
    nx();
    call_req = 1'b0;
    push_req = 1'b1;
    chk("busy", 16'(busy), 16'h0001);
    nx();
    push_req = 1'b0;
    chk("pc_q", pc_q, 16'h4000);
    sfr_get(8'h81, 8'h09);
    xmov_addr = 8'h08;
    grab(xmov_rd, xmov_valid, 8'h34);
    xmov_addr = 8'h09;
    grab(xmov_rd, xmov_valid, 8'h12);
    strobe(ret_req);
    nx();
    chk("pc_q", pc_q, 16'h1234);
    sfr_get(8'h81, 8'h07);
    conclude();
  end
endmodule
